// ---- dv/clock_software_model.sv ----
// Software side of the clock block: an Avalon-MM master that waits on waitrequest.
module clock_software_model (
  input wire logic clk_in,
  input wire logic [31:0] readdata_in,
  input wire logic waitrequest_in,
  output logic [11:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  output logic [3:0] byteenable_out,
  output logic hang_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // The bus starts idle so nothing is requested during reset.
  initial begin
    address_out = 12'h000;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0;
    byteenable_out = 4'h0;
    hang_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One access, held until waitrequest is sampled low; a stuck slave raises hang_out.
  task automatic access(input logic rd, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    address_out <= a;
    read_out <= rd;
    write_out <= !rd;
    writedata_out <= d;
    byteenable_out <= be;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_in !== 1'b0 && n < 64);
    if (waitrequest_in !== 1'b0) hang_out <= 1'b1;
    q = readdata_in;
    read_out <= 1'b0;
    write_out <= 1'b0;
    // Released lines flip so that a stale address or data word cannot pass for a live one.
    address_out <= ~a;
    writedata_out <= ~d;
  endtask

  // Read-modify-write that keeps every bit outside the mask, reserved ones too.
  task automatic modify(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] v);
    logic [31:0] q;
    access(1'b1, a, 32'h0, 4'hf, q);
    access(1'b0, a, (q & ~mask) | (v & mask), 4'hf, q);
  endtask
endmodule // clock_software_model

// ---- dv/osc_select_pll_translate_tb.sv ----
`include "osc_pll_params.svh"

module osc_select_pll_translate_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import osc_pll_pkg::*;

  localparam logic [11:0] CFG = `RUN_CLOCK_CONFIG_OFFSET;
  localparam logic [11:0] XL = `CRYSTAL_PLL_TRANSLATION_OFFSET;
  // Expected translation per crystal code, and crystal frequency in units of 100 Hz.
  localparam logic [15:0] XL_TAB [16] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h37e3, 16'h1b21,
    16'h0c80, 16'h30e3, 16'h1e82, 16'h0a00, 16'h30e4, 16'h1902, 16'h30e5, 16'h1b23,
    16'h0640, 16'h30e7};
  localparam int FQ [16] = '{0, 0, 0, 0, 35795, 36864, 40000, 40960, 49152, 50000, 51200,
    60000, 61440, 73728, 80000, 81920};

  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [11:0] addr;
  logic rd, wr, wait_req, hang, main_en, int_en, from_pll, unsup, bad_src;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [1:0] oscale;
  logic [8:0] mult;
  logic [4:0] iscale;
  osc_source_e src_sel;
  int compares = 0;
  int miscompares = 0;

  // 10 MHz clock.
  always #50 clk_in = ~clk_in;

  osc_pll_control uut (.clk_in(clk_in), .reset_in(reset_in), .address_in(addr),
    .read_in(rd), .write_in(wr), .writedata_in(wdata), .byteenable_in(be),
    .readdata_out(rdata), .waitrequest_out(wait_req), .main_osc_enable_out(main_en),
    .internal_osc_enable_out(int_en), .oscillator_source_select_out(src_sel),
    .system_clock_from_pll_out(from_pll), .pll_output_scale_out(oscale),
    .pll_multiplier_out(mult), .pll_input_scale_out(iscale),
    .crystal_unsupported_out(unsup), .pll_source_invalid_out(bad_src));

  clock_software_model sw (.clk_in(clk_in), .readdata_in(rdata), .waitrequest_in(wait_req),
    .address_out(addr), .read_out(rd), .write_out(wr), .writedata_out(wdata),
    .byteenable_out(be), .hang_out(hang));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A slave that never answers ends the run as a failure.
  always @(posedge hang) begin
    miscompares++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Defaults: main stopped, internal running, source 01, bypass, crystal code 1011.
  task automatic check_reset();
    logic [31:0] q;
    sw.access(1'b1, CFG, 32'h0, 4'hf, q);
    check(q, 32'had1);
    sw.access(1'b1, XL, 32'h0, 4'hf, q);
    check(q, 32'h1902);
    check({main_en, int_en, src_sel, from_pll}, 5'b01010);
    check({oscale, mult, iscale}, 16'h1902);
  endtask

  // Every crystal code with the PLL fed from internal/4; the target frequency is common.
  task automatic sweep_codes();
    logic [31:0] q;
    logic [15:0] e;
    int f;
    for (int c = 0; c < 16; c++) begin
      e = XL_TAB[c];
      sw.access(1'b0, CFG, {22'h0, 4'(c), 2'b10, 4'h0}, 4'hf, q);
      sw.access(1'b1, XL, 32'h0, 4'hf, q);
      check(q, {16'h0, e});
      @(negedge clk_in);
      check({oscale, mult, iscale}, e);
      check({unsup, bad_src, from_pll}, {c < 4, 2'b01});
      if (c >= 4) begin
        f = FQ[c] * int'(e[13:5]) / (int'(e[4:0]) + 1);
        check(f > 3980000 && f < 4020000, 1'b1);
      end
    end
  endtask

  // Every source code with the disable and bypass bits; reserved 3:2 written as ones.
  task automatic sweep_controls();
    logic [31:0] q, w;
    for (int v = 0; v < 16; v++) begin
      w = {20'h0, v[3], 1'b0, 4'hb, v[1:0], 2'b11, v[3], v[2]};
      sw.access(1'b0, CFG, w, 4'hf, q);
      #1;
      check({main_en, int_en, src_sel}, {!v[2], !v[3], v[1:0]});
      check({from_pll, bad_src, unsup}, {!v[3], !v[3] && v[1:0] == 2'b01, 1'b0});
      sw.access(1'b1, CFG, 32'h0, 4'hf, q);
      check(q, w & ~32'hc);
    end
  endtask

  // Byte lanes alter only their own bits; the translation follows a partial code write.
  task automatic lanes_and_refusals();
    logic [31:0] q;
    sw.access(1'b0, CFG, 32'h0, 4'hf, q);
    sw.access(1'b0, CFG, 32'hffffffff, 4'h1, q);
    sw.access(1'b1, CFG, 32'h0, 4'hf, q);
    check(q, 32'h0f3);
    sw.access(1'b1, XL, 32'h0, 4'hf, q);
    check(q, 32'h0);
    sw.access(1'b0, CFG, 32'hffffffff, 4'h2, q);
    sw.access(1'b0, XL, 32'h0, 4'hf, q);
    sw.access(1'b0, 12'h100, 32'h0, 4'hf, q);
    sw.access(1'b1, XL, 32'h0, 4'hf, q);
    check(q, 32'h30e7);
    sw.access(1'b1, CFG, 32'h0, 4'hf, q);
    check(q, 32'hbf3);
    sw.access(1'b1, 12'h100, 32'h0, 4'hf, q);
    check(q, 32'h0);
  endtask

  // Reset in mid-run restores defaults; a masked code update keeps the other fields.
  task automatic mid_reset();
    logic [31:0] q;
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    check_reset();
    sw.modify(CFG, 32'h3c0, 32'h100);
    sw.access(1'b1, CFG, 32'h0, 4'hf, q);
    check(q, 32'h911);
    sw.access(1'b1, XL, 32'h0, 4'hf, q);
    check(q, 32'h37e3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    check_reset();
    sweep_codes();
    sweep_controls();
    lanes_and_refusals();
    mid_reset();
    conclude();
  end
endmodule // osc_select_pll_translate_tb

// ---- src/crystal_translator.sv ----
`include "osc_pll_params.svh"

module crystal_translator (
  input wire logic clk_in,
  xlate_if.translator xl
);
  import osc_pll_pkg::*;

  pll_setting_s setting;
  logic supported;
  pll_setting_s next_setting;
  logic next_supported;

  // Every supported crystal lands near a 400 MHz PLL output with the output
  // scale at zero; the ratios are integer approximations, within 0.2 percent.
  function automatic pll_setting_s lookup(input logic [3:0] code);
    pll_setting_s s;
    s = '0;
    unique case (code)
      4'h4: s = '{2'h0, 9'h1bf, 5'h03};
      4'h5: s = '{2'h0, 9'h0d9, 5'h01};
      4'h6: s = '{2'h0, 9'h064, 5'h00};
      4'h7: s = '{2'h0, 9'h187, 5'h03};
      4'h8: s = '{2'h0, 9'h0f4, 5'h02};
      4'h9: s = '{2'h0, 9'h050, 5'h00};
      4'ha: s = '{2'h0, 9'h187, 5'h04};
      4'hb: s = '{2'h0, 9'h0c8, 5'h02};
      4'hc: s = '{2'h0, 9'h187, 5'h05};
      4'hd: s = '{2'h0, 9'h0d9, 5'h03};
      4'he: s = '{2'h0, 9'h032, 5'h00};
      4'hf: s = '{2'h0, 9'h187, 5'h07};
      default: s = '0;
    endcase
    return s;
  endfunction

  // During reset the reset crystal code is translated; afterwards the code
  // being written is used, so the value is fresh at the same edge.
  assign next_setting = xl.load_reset ?
      lookup(`CRYSTAL_CODE_RESET) : lookup(xl.next_crystal_code);
  assign next_supported = xl.load_reset ?
      1'b1 : (xl.next_crystal_code >= `CRYSTAL_MIN_PLL_CODE);

  // Result register.
  always_ff @(posedge clk_in) begin
    setting <= next_setting;
    supported <= next_supported;
  end

  assign xl.setting = setting;
  assign xl.supported = supported;
endmodule // crystal_translator

// ---- src/osc_pll_control.sv ----
// Local design decision: the Avalon-MM interface to the registers.
`include "osc_pll_params.svh"

// Functional notes
// - Two-bit source select at 5:4, reset 01.
// - Bit 1 stops internal oscillator, reset 0.
// - Bit 0 stops main oscillator, reset 1.
// - Reserved bits read zero, software preserves them.
// - Four-bit crystal code names attached crystal.
// - Codes below 0100 unsupported; reset 1011.
// - Translation loaded at reset, follows crystal code.
// - PLL equals oscillator times multiplier over scale+1.
// - Translation register read-only at 0x064.
// - Bits 15:14 drive PLL output divider.
// - Bits 13:5 drive PLL multiplier.
// - Bits 4:0 drive PLL reference divider.
// - Bypass bit 11 selects oscillator over PLL.
module osc_pll_control (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [11:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic main_osc_enable_out,
  output logic internal_osc_enable_out,
  output osc_pll_pkg::osc_source_e oscillator_source_select_out,
  output logic system_clock_from_pll_out,
  output logic [1:0] pll_output_scale_out,
  output logic [8:0] pll_multiplier_out,
  output logic [4:0] pll_input_scale_out,
  output logic crystal_unsupported_out,
  output logic pll_source_invalid_out
);
  import osc_pll_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  bus_phase_e phase;
  bus_phase_e next_phase;
  logic [31:0] readdata;
  logic request;
  logic accept;
  logic hit_run_clock;
  logic hit_translation;
  logic write_run_clock;
  logic [31:0] read_mux;

  // A request is held in wait for exactly one cycle, then answered.
  assign request = read_in | write_in;
  assign waitrequest_out = request && (phase == bus_idle);
  assign accept = request && (phase == bus_answer);
  assign hit_run_clock = (address_in == `RUN_CLOCK_CONFIG_OFFSET);
  assign hit_translation = (address_in == `CRYSTAL_PLL_TRANSLATION_OFFSET);
  assign write_run_clock = write_in && accept && hit_run_clock;
  assign next_phase = waitrequest_out ? bus_answer : bus_idle;

  // Phase register; a dropped request simply returns the slave to idle.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase <= bus_idle;
    end else begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run-mode clock register.

  logic main_osc_disable;
  logic internal_osc_disable;
  osc_source_e osc_source;
  logic [3:0] crystal_code;
  logic pll_bypass;
  logic [31:0] run_clock_image;
  logic [31:0] write_mask;
  logic [31:0] merged;
  logic [3:0] next_crystal_code;

  // Byte enables widen to a bit mask, one byte lane per iteration.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign write_mask[8*b +: 8] = {8{byteenable_in[b]}};
  end

  // Current register image; unimplemented bits read as zero.
  always_comb begin
    run_clock_image = '0;
    run_clock_image[`MAIN_OSC_DISABLE_BIT] = main_osc_disable;
    run_clock_image[`INTERNAL_OSC_DISABLE_BIT] = internal_osc_disable;
    run_clock_image[`OSC_SOURCE_MSB:`OSC_SOURCE_LSB] = osc_source;
    run_clock_image[`CRYSTAL_CODE_MSB:`CRYSTAL_CODE_LSB] = crystal_code;
    run_clock_image[`PLL_BYPASS_BIT] = pll_bypass;
  end

  // Byte-masked merge keeps unwritten lanes, so a narrow write is safe.
  assign merged = (run_clock_image & ~write_mask) | (writedata_in & write_mask);
  assign next_crystal_code = write_run_clock ?
      merged[`CRYSTAL_CODE_MSB:`CRYSTAL_CODE_LSB] : crystal_code;

  // Field storage; a write lands at the edge where waitrequest is low.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      main_osc_disable <= `MAIN_OSC_DISABLE_RESET;
      internal_osc_disable <= `INTERNAL_OSC_DISABLE_RESET;
      osc_source <= osc_source_e'(`OSC_SOURCE_RESET);
      crystal_code <= `CRYSTAL_CODE_RESET;
      pll_bypass <= `PLL_BYPASS_RESET;
    end else if (write_run_clock) begin
      main_osc_disable <= merged[`MAIN_OSC_DISABLE_BIT];
      internal_osc_disable <= merged[`INTERNAL_OSC_DISABLE_BIT];
      osc_source <= osc_source_e'(merged[`OSC_SOURCE_MSB:`OSC_SOURCE_LSB]);
      crystal_code <= next_crystal_code;
      pll_bypass <= merged[`PLL_BYPASS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translation.

  xlate_if xl ();

  // The translator sees the value about to be stored, which keeps a read
  // right after a crystal write from returning stale PLL values.
  assign xl.next_crystal_code = next_crystal_code;
  assign xl.load_reset = reset_in;

  crystal_translator u_translator (
    .clk_in(clk_in),
    .xl(xl)
  );

  logic [31:0] translation_image;

  // The register only reflects the translator; writes never reach it.
  always_comb begin
    translation_image = '0;
    translation_image[`PLL_OUTPUT_SCALE_MSB:`PLL_OUTPUT_SCALE_LSB] =
        xl.setting.output_scale;
    translation_image[`PLL_MULTIPLIER_MSB:`PLL_MULTIPLIER_LSB] = xl.setting.multiplier;
    translation_image[`PLL_INPUT_SCALE_MSB:`PLL_INPUT_SCALE_LSB] = xl.setting.input_scale;
  end

  // Read selection; unmapped addresses read as zero and ignore writes.
  assign read_mux = hit_run_clock ? run_clock_image :
      (hit_translation ? translation_image : 32'h0);

  // Read data is captured in the wait cycle and stands in the answer cycle.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      readdata <= '0;
    end else if (waitrequest_out && read_in) begin
      readdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Clock controls come straight from the fields, so they follow the write
  // edge with no extra delay.
  assign readdata_out = readdata;
  assign main_osc_enable_out = !main_osc_disable;
  assign internal_osc_enable_out = !internal_osc_disable;
  assign oscillator_source_select_out = osc_source;
  assign system_clock_from_pll_out = !pll_bypass;
  assign pll_output_scale_out = xl.setting.output_scale;
  assign pll_multiplier_out = xl.setting.multiplier;
  assign pll_input_scale_out = xl.setting.input_scale;

  // Warnings only: the hardware does not override a bad software choice.
  assign crystal_unsupported_out = !pll_bypass && !xl.supported;
  assign pll_source_invalid_out = !pll_bypass && (osc_source == src_internal);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  logic write_translation;
  assign write_translation = write_in && accept && hit_translation;

  sequence s_wait;
    request && waitrequest_out;
  endsequence

  sequence s_low_write;
    write_run_clock && byteenable_in[0];
  endsequence

  sequence s_high_write;
    write_run_clock && byteenable_in[1];
  endsequence

  property p_bus_answer;
    s_wait ##1 request |-> !waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Request not answered after one wait cycle.");

  property p_main_osc;
    s_low_write |=> main_osc_enable_out == !$past(writedata_in[0]);
  endproperty
  a_main_osc: assert property (p_main_osc)
    else $error("Main oscillator enable does not follow the write.");

  property p_internal_osc;
    s_low_write |=> internal_osc_enable_out == !$past(writedata_in[1]);
  endproperty
  a_internal_osc: assert property (p_internal_osc)
    else $error("Internal oscillator enable does not follow the write.");

  property p_source;
    s_low_write |=> oscillator_source_select_out == $past(writedata_in[5:4]);
  endproperty
  a_source: assert property (p_source)
    else $error("Source select does not follow the write.");

  property p_reserved_zero;
    read_in && accept && hit_run_clock |->
      readdata_out[3:2] == 2'h0 && readdata_out[31:12] == 20'h0 && !readdata_out[10];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved clock register bits read nonzero.");

  property p_translation_read;
    read_in && accept && hit_translation |->
      readdata_out == {16'h0, pll_output_scale_out, pll_multiplier_out, pll_input_scale_out};
  endproperty
  a_translation_read: assert property (p_translation_read)
    else $error("Translation readback differs from PLL outputs.");

  property p_read_only;
    write_translation |=> $stable(pll_multiplier_out) && $stable(pll_input_scale_out);
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("Write to translation register changed it.");

  property p_six_mhz;
    s_high_write ##0 (merged[9:6] == 4'hb) |=>
      pll_multiplier_out == 9'h0c8 && pll_input_scale_out == 5'h02;
  endproperty
  a_six_mhz: assert property (p_six_mhz)
    else $error("Six megahertz crystal not translated to 200 over 3.");

  property p_unsupported;
    s_high_write ##0 (merged[9:6] < 4'h4) |=> pll_multiplier_out == 9'h0;
  endproperty
  a_unsupported: assert property (p_unsupported)
    else $error("Unsupported crystal code still drives a multiplier.");

  property p_reset_defaults;
    $fell(reset_in) |-> !main_osc_enable_out && internal_osc_enable_out &&
      oscillator_source_select_out == src_internal && !system_clock_from_pll_out &&
      pll_multiplier_out == 9'h0c8;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Outputs wrong at reset release.");

  property p_bypass;
    s_high_write |=> system_clock_from_pll_out == !$past(writedata_in[11]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Bypass does not follow the write.");

  // A fresh request always spends its first cycle waiting.
  property p_wait_first;
    $rose(request) |-> waitrequest_out;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("Fresh request was not held for a wait cycle.");

  // Without a register write the clock controls must not move.
  property p_fields_hold;
    !write_run_clock |=> $stable(main_osc_enable_out) && $stable(internal_osc_enable_out) &&
      $stable(oscillator_source_select_out) && $stable(system_clock_from_pll_out);
  endproperty
  a_fields_hold: assert property (p_fields_hold)
    else $error("Clock controls changed without a write.");

  // The PLL values move only when the crystal code is written.
  property p_translation_hold;
    !write_run_clock |=> $stable(pll_output_scale_out) && $stable(pll_multiplier_out) &&
      $stable(pll_input_scale_out);
  endproperty
  a_translation_hold: assert property (p_translation_hold)
    else $error("PLL values changed without a crystal code write.");

  // Read data stands between captures, so a slow master still sees it.
  property p_readdata_hold;
    !(waitrequest_out && read_in) |=> $stable(readdata_out);
  endproperty
  a_readdata_hold: assert property (p_readdata_hold)
    else $error("Read data changed outside a capture.");

  // A clock register read reports the fields that drive the outputs.
  property p_config_readback;
    read_in && accept && hit_run_clock |->
      readdata_out[0] == !main_osc_enable_out && readdata_out[1] == !internal_osc_enable_out &&
      readdata_out[5:4] == oscillator_source_select_out &&
      readdata_out[11] == !system_clock_from_pll_out;
  endproperty
  a_config_readback: assert property (p_config_readback)
    else $error("Clock register readback differs from the outputs.");

  // Unmapped reads return zero, so stray software sees nothing live.
  property p_unmapped_read;
    read_in && accept && !hit_run_clock && !hit_translation |-> readdata_out == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped address read nonzero.");

  // Only the reserved low codes translate to a zero multiplier.
  property p_unsupported_flag;
    crystal_unsupported_out == (system_clock_from_pll_out && pll_multiplier_out == 9'h0);
  endproperty
  a_unsupported_flag: assert property (p_unsupported_flag)
    else $error("Unsupported crystal warning disagrees with the multiplier.");

  // With the PLL bypassed neither warning may be raised.
  property p_bypass_flags;
    !system_clock_from_pll_out |-> !crystal_unsupported_out && !pll_source_invalid_out;
  endproperty
  a_bypass_flags: assert property (p_bypass_flags)
    else $error("Warning raised while the PLL is bypassed.");

  // The undivided internal oscillator feeding the PLL must be flagged.
  property p_source_invalid;
    system_clock_from_pll_out && oscillator_source_select_out == src_internal |->
      pll_source_invalid_out;
  endproperty
  a_source_invalid: assert property (p_source_invalid)
    else $error("Undivided internal source feeding the PLL not flagged.");

  // The fastest crystal uses the deepest input scale.
  property p_top_code;
    s_high_write ##0 (merged[9:6] == 4'hf) |=>
      pll_multiplier_out == 9'h187 && pll_input_scale_out == 5'h07;
  endproperty
  a_top_code: assert property (p_top_code)
    else $error("Top crystal code not translated to 391 over 8.");

  // The slowest supported crystal needs the largest multiplier.
  property p_low_code;
    s_high_write ##0 (merged[9:6] == 4'h4) |=>
      pll_multiplier_out == 9'h1bf && pll_input_scale_out == 5'h03;
  endproperty
  a_low_code: assert property (p_low_code)
    else $error("Lowest supported crystal code not translated to 447 over 4.");

endmodule // osc_pll_control

// ---- src/osc_pll_params.svh ----
`ifndef OSC_PLL_PARAMS_SVH
`define OSC_PLL_PARAMS_SVH

// Byte addresses of the two registers on the Avalon slave.
`define ADDR_WIDTH 12
`define RUN_CLOCK_CONFIG_OFFSET 12'h060
`define CRYSTAL_PLL_TRANSLATION_OFFSET 12'h064

// Field positions in the run-mode clock register.
`define MAIN_OSC_DISABLE_BIT 0
`define INTERNAL_OSC_DISABLE_BIT 1
`define RESERVED_LOW_MSB 3
`define RESERVED_LOW_LSB 2
`define OSC_SOURCE_MSB 5
`define OSC_SOURCE_LSB 4
`define CRYSTAL_CODE_MSB 9
`define CRYSTAL_CODE_LSB 6
`define PLL_BYPASS_BIT 11

// Field positions in the translation register.
`define PLL_OUTPUT_SCALE_MSB 15
`define PLL_OUTPUT_SCALE_LSB 14
`define PLL_MULTIPLIER_MSB 13
`define PLL_MULTIPLIER_LSB 5
`define PLL_INPUT_SCALE_MSB 4
`define PLL_INPUT_SCALE_LSB 0
`define TRANSLATION_USED_BITS 16

// Reset values.
`define MAIN_OSC_DISABLE_RESET 1'b1
`define INTERNAL_OSC_DISABLE_RESET 1'b0
`define OSC_SOURCE_RESET 2'h1
`define CRYSTAL_CODE_RESET 4'hb
`define PLL_BYPASS_RESET 1'b1

// Lowest crystal code that the PLL accepts.
`define CRYSTAL_MIN_PLL_CODE 4'h4

// Cycles from a request to the cycle in which waitrequest is low.
`define BUS_ANSWER_CYCLES 1

`endif

// ---- src/osc_pll_pkg.sv ----
package osc_pll_pkg;

  // Oscillator source codes.
  typedef enum logic [1:0] {
    src_main = 2'b00,
    src_internal = 2'b01,
    src_internal_div4 = 2'b10,
    src_reserved = 2'b11
  } osc_source_e;

  // Phase of the Avalon slave.
  typedef enum logic {
    bus_idle = 1'b0,
    bus_answer = 1'b1
  } bus_phase_e;

  // One set of PLL programming values.
  typedef struct packed {
    logic [1:0] output_scale;
    logic [8:0] multiplier;
    logic [4:0] input_scale;
  } pll_setting_s;

endpackage

// ---- src/xlate_if.sv ----
// Carries the crystal code to the translator and the PLL values back.
interface xlate_if;
  logic [3:0] next_crystal_code;
  logic load_reset;
  osc_pll_pkg::pll_setting_s setting;
  logic supported;

  modport requester (
    output next_crystal_code,
    output load_reset,
    input setting,
    input supported
  );

  modport translator (
    input next_crystal_code,
    input load_reset,
    output setting,
    output supported
  );
endinterface
